// >>> ipis_pkg.sv
// Package with timing constants and state encoding for the intermittent pilot ignition sequencer
package ipis_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICK_CYCLES = CLK_HZ;
  localparam int unsigned TRIAL_TIME_S = 90;
  localparam int unsigned RETRY_TIME_MIN = 5;
  localparam int unsigned RETRY_TIME_S = RETRY_TIME_MIN * 60;
  localparam int unsigned STABILISE_TIME_S = 2;
  localparam int unsigned LOCK_CYCLE_COUNT = 10;
  localparam int unsigned DEBOUNCE_CYCLES = 16;
  localparam int unsigned CFG_W = 2;
  localparam logic [CFG_W-1:0] CFG_RESET = 2'h0;
  typedef enum logic [2:0] {
    IPIS_IDLE,
    IPIS_TRIAL,
    IPIS_STABILISE,
    IPIS_RUN,
    IPIS_RETRY_WAIT
  } ipis_state_t;
endpackage : ipis_pkg

// >>> ipis_sync_if.sv
// Interface carrying the conditioned inputs from the input filter to the sequencer
`timescale 1ns/1ps
interface ipis_sync_if;
  logic heat;
  logic flame_low;
  logic flame_high;
  modport filt (output heat, output flame_low, output flame_high);
  modport seq (input heat, input flame_low, input flame_high);
endinterface : ipis_sync_if

// >>> ipis_in_filter.sv
// Three-stage synchroniser and debounce filter for the heat request and flame threshold inputs
`timescale 1ns/1ps
module ipis_in_filter #(
  parameter int unsigned DEB_CYCLES = 16
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Raw inputs
  input wire logic [2:0] raw_i,
  // Conditioned outputs
  ipis_sync_if.filt sync_o
);
  localparam int unsigned CW = $clog2(DEB_CYCLES + 1);
  if (DEB_CYCLES < 1) begin : g_bad_deb
    $error("DEB_CYCLES must be at least 1");
  end
  logic [2:0] clean;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ch
      logic s1;
      logic s2;
      logic s3;
      logic [CW-1:0] cnt;
      always_ff @(posedge mclk_i) begin
        if (rst_i) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
        end else begin
          s1 <= raw_i[g];
          s2 <= s1;
          s3 <= s2;
        end
      end
      // A level counts only after the last two stages agree for the full debounce span
      always_ff @(posedge mclk_i) begin
        if (rst_i) begin
          cnt <= '0;
          clean[g] <= 1'b0;
        end else if (s2 != s3 || s3 == clean[g]) begin
          cnt <= '0;
        end else if (cnt == CW'(DEB_CYCLES - 1)) begin
          cnt <= '0;
          clean[g] <= s3;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  endgenerate
  assign sync_o.heat = clean[0];
  assign sync_o.flame_low = clean[1];
  assign sync_o.flame_high = clean[2];
endmodule : ipis_in_filter

// >>> ipis_sequencer.sv
// Intermittent pilot ignition sequencer: trial, flame proving, run supervision and retry timing
`timescale 1ns/1ps
module ipis_sequencer
  import ipis_pkg::*;
#(
  parameter int unsigned TICK_CYC = ipis_pkg::TICK_CYCLES,
  parameter int unsigned TRIAL_S = ipis_pkg::TRIAL_TIME_S,
  parameter int unsigned RETRY_S = ipis_pkg::RETRY_TIME_S,
  parameter int unsigned STAB_S = ipis_pkg::STABILISE_TIME_S,
  parameter int unsigned DEB_CYC = ipis_pkg::DEBOUNCE_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Thermostat and flame sensing
  input wire logic heat_request_input_i,
  input wire logic flame_low_i,
  input wire logic flame_high_i,
  // Configuration
  input wire logic setting_lock_jumper_i,
  input wire logic [ipis_pkg::CFG_W-1:0] cfg_switch_i,
  // Outputs
  output logic spark_o,
  output logic pilot_valve_output_o,
  output logic main_valve_output_o,
  output logic run_o,
  output logic cfg_locked_o,
  output logic [ipis_pkg::CFG_W-1:0] cfg_o
);
  import ipis_pkg::*;

  localparam int unsigned TW = $clog2(TICK_CYC);
  localparam int unsigned SW = $clog2(RETRY_S + TRIAL_S + STAB_S + 1);

  if (TICK_CYC < 2) begin : g_bad_tick
    $error("TICK_CYC must be at least 2");
  end
  if (TRIAL_S < 1 || RETRY_S < 1 || STAB_S < 1) begin : g_bad_time
    $error("Timing values must be at least 1 second");
  end

  ipis_sync_if sif ();
  logic jumper_present;

  ipis_in_filter #(
    .DEB_CYCLES(DEB_CYC)
  ) u_filter (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .raw_i({flame_high_i, flame_low_i, heat_request_input_i}),
    .sync_o(sif)
  );

  // The jumper is a slow pin too; three stages, change accepted when last two agree
  logic [2:0] jmp_sync;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      jmp_sync <= 3'h7;
      jumper_present <= 1'b1;
    end else begin
      jmp_sync <= {jmp_sync[1:0], setting_lock_jumper_i};
      if (jmp_sync[2] == jmp_sync[1]) begin
        jumper_present <= jmp_sync[2];
      end
    end
  end

  // Free-running seconds prescaler
  logic [TW-1:0] pre_cnt;
  logic sec_tick;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pre_cnt <= '0;
      sec_tick <= 1'b0;
    end else if (pre_cnt == TW'(TICK_CYC - 1)) begin
      pre_cnt <= '0;
      sec_tick <= 1'b1;
    end else begin
      pre_cnt <= pre_cnt + 1'b1;
      sec_tick <= 1'b0;
    end
  end

  ipis_state_t state;
  ipis_state_t next_state;
  logic [SW-1:0] sec_cnt;
  logic heat_d;
  logic heat_rise;
  logic timer_clear;

  assign heat_rise = sif.heat && !heat_d;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      heat_d <= 1'b0;
    end else begin
      heat_d <= sif.heat;
    end
  end

  // Sequencing; the seconds count is whole ticks since the state was entered
  always_comb begin
    next_state = state;
    unique case (state)
      IPIS_IDLE: begin
        if (heat_rise) next_state = IPIS_TRIAL;
      end
      IPIS_TRIAL: begin
        if (!sif.heat) begin
          next_state = IPIS_IDLE;
        end else if (sif.flame_high && sif.flame_low) begin
          next_state = IPIS_STABILISE;
        end else if (sec_tick && sec_cnt == SW'(TRIAL_S - 1)) begin
          next_state = IPIS_RETRY_WAIT;
        end
      end
      IPIS_STABILISE: begin
        if (!sif.heat || !sif.flame_low) begin
          next_state = IPIS_IDLE;
        end else if (sec_tick && sec_cnt == SW'(STAB_S - 1)) begin
          next_state = IPIS_RUN;
        end
      end
      IPIS_RUN: begin
        if (!sif.heat || !sif.flame_low) next_state = IPIS_IDLE;
      end
      IPIS_RETRY_WAIT: begin
        if (!sif.heat) begin
          next_state = IPIS_IDLE;
        end else if (sec_tick && sec_cnt == SW'(RETRY_S - 1)) begin
          next_state = IPIS_TRIAL;
        end
      end
    endcase
  end

  assign timer_clear = (next_state != state);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state <= IPIS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i || timer_clear) begin
      sec_cnt <= '0;
    end else if (sec_tick) begin
      sec_cnt <= sec_cnt + 1'b1; // Trial timer keeps running even when spark restarts
    end
  end

  // Outputs follow the next state so spark and pilot rise together on the entry edge
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      spark_o <= 1'b0;
      pilot_valve_output_o <= 1'b0;
      main_valve_output_o <= 1'b0;
      run_o <= 1'b0;
    end else begin
      // Spark stops above the low threshold and comes back if the flame weakens
      spark_o <= (next_state == IPIS_TRIAL) && !sif.flame_low;
      pilot_valve_output_o <= (next_state == IPIS_TRIAL) || (next_state == IPIS_STABILISE) ||
                              (next_state == IPIS_RUN);
      main_valve_output_o <= (next_state == IPIS_STABILISE) || (next_state == IPIS_RUN);
      run_o <= (next_state == IPIS_RUN);
    end
  end

  // Switch pins are asynchronous; a new setting counts once the last two stages agree
  logic [CFG_W-1:0] sw_s1;
  logic [CFG_W-1:0] sw_s2;
  logic [CFG_W-1:0] sw_s3;
  logic [CFG_W-1:0] sw_clean;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sw_s1 <= CFG_RESET;
      sw_s2 <= CFG_RESET;
      sw_s3 <= CFG_RESET;
      sw_clean <= CFG_RESET;
    end else begin
      sw_s1 <= cfg_switch_i;
      sw_s2 <= sw_s1;
      sw_s3 <= sw_s2;
      if (sw_s2 == sw_s3) begin
        sw_clean <= sw_s3;
      end
    end
  end

  // Configuration lock: cycle counter counts heat request starts, saturating at the limit
  logic [3:0] cycle_cnt;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cycle_cnt <= '0;
    end else if (heat_rise && cycle_cnt != 4'(LOCK_CYCLE_COUNT)) begin
      cycle_cnt <= cycle_cnt + 1'b1;
    end
  end

  // Lock is sticky until reset; a reinserted jumper cannot undo it
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cfg_locked_o <= 1'b0;
      cfg_o <= CFG_RESET;
    end else begin
      if (!jumper_present || (heat_rise && cycle_cnt == 4'(LOCK_CYCLE_COUNT - 1))) begin
        cfg_locked_o <= 1'b1;
      end
      if (!cfg_locked_o && jumper_present && !(heat_rise && cycle_cnt == 4'(LOCK_CYCLE_COUNT - 1))) begin
        cfg_o <= sw_clean;
      end
    end
  end
endmodule : ipis_sequencer

// >>> ipis_seq_assertions.sv
// Port-level assertion checker for the ignition sequencer
`timescale 1ns/1ps
module ipis_seq_assertions #(
  parameter int unsigned TICK_CYC = ipis_pkg::TICK_CYCLES,
  parameter int unsigned TRIAL_S = ipis_pkg::TRIAL_TIME_S
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Watched inputs
  input wire logic heat_request_input_i,
  input wire logic flame_low_i,
  input wire logic flame_high_i,
  // Watched outputs
  input wire logic spark_o,
  input wire logic pilot_valve_output_o,
  input wire logic main_valve_output_o,
  input wire logic run_o,
  input wire logic cfg_locked_o,
  input wire logic [ipis_pkg::CFG_W-1:0] cfg_o
);
  // Wide count: the full-speed trial span does not fit in 32 bits
  localparam longint TLIM = longint'(TRIAL_S) * TICK_CYC + 1;
  longint trial_cnt;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // Pilot gas time without main proof; spark restarts must not extend it
  always_ff @(posedge mclk_i) begin
    if (rst_i || !pilot_valve_output_o || main_valve_output_o) trial_cnt <= 0;
    else trial_cnt <= trial_cnt + 1;
  end
  sequence flame_gone; !flame_low_i [*8]; endsequence
  sequence heat_gone; !heat_request_input_i [*8]; endsequence
  trial_start_a: assert property ($rose(pilot_valve_output_o) |-> spark_o) else $error("pilot without spark");
  trial_limit_a: assert property (trial_cnt <= TLIM) else $error("trial too long");
  spark_stop_a: assert property (flame_low_i [*8] |-> !spark_o) else $error("spark kept on");
  main_proof_a: assert property ($rose(main_valve_output_o) |-> $past(flame_high_i, 3) && !spark_o)
    else $error("main without proof");
  stab_first_a: assert property ($rose(run_o) |-> $past(main_valve_output_o, 8) && main_valve_output_o)
    else $error("run too early");
  flame_loss_a: assert property (run_o ##0 flame_gone |=> !pilot_valve_output_o && !main_valve_output_o)
    else $error("gas on after loss");
  heat_end_a: assert property (heat_gone |=> !spark_o && !pilot_valve_output_o && !main_valve_output_o)
    else $error("gas on without heat");
  cfg_hold_a: assert property (cfg_locked_o |=> cfg_locked_o && $stable(cfg_o)) else $error("cfg moved");
endmodule : ipis_seq_assertions

// >>> ipis_flame_model.sv
// Flame sensor model: flame lights only with pilot gas, spark and gas supply, then grows without spark
`timescale 1ns/1ps
module ipis_flame_model (
  // Clock
  input wire logic mclk_i,
  // Burner state
  input wire logic gas_ok_i,
  input wire logic pilot_i,
  input wire logic spark_i,
  // Flame thresholds
  output logic flame_low_o,
  output logic flame_high_o
);
  logic [3:0] age;
  // No gas or no pilot valve puts the flame out at once
  always_ff @(posedge mclk_i) begin
    if (!pilot_i || !gas_ok_i) age <= 4'h0;
    else if ((spark_i || age != 4'h0) && age != 4'hF) age <= age + 4'h1;
  end
  assign flame_low_o = age > 4'h3;
  // High threshold well above the low one leaves room to starve a weak flame
  assign flame_high_o = age > 4'hC;
endmodule : ipis_flame_model

// >>> tb_ipis_sequencer.sv
// Self-checking testbench for the ignition sequencer
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin failures++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module tb_ipis_sequencer;
  import ipis_pkg::*;
  localparam int TK = 10;
  localparam int TR = 90;
  localparam int RT = 300;
  localparam int ST = 2;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic heat = 1'b0;
  logic gas_ok = 1'b0;
  logic jumper = 1'b1;
  logic [CFG_W-1:0] sw = 2'h0;
  logic flame_low, flame_high, spark, pilot, main_v, run, locked;
  logic [CFG_W-1:0] cfg;
  wire [3:0] outs = {spark, pilot, main_v, run};
  int failures = 0;
  int n_checks = 0;
  int n;
  always #2.5 mclk_i = ~mclk_i;
  ipis_sequencer #(.TICK_CYC(TK), .TRIAL_S(TR), .RETRY_S(RT), .STAB_S(ST), .DEB_CYC(2)) i_ipis_sequencer (
    .mclk_i(mclk_i), .rst_i(rst_i), .heat_request_input_i(heat), .flame_low_i(flame_low),
    .flame_high_i(flame_high), .setting_lock_jumper_i(jumper), .cfg_switch_i(sw), .spark_o(spark),
    .pilot_valve_output_o(pilot), .main_valve_output_o(main_v), .run_o(run), .cfg_locked_o(locked), .cfg_o(cfg));
  ipis_flame_model i_ipis_flame_model (.mclk_i(mclk_i), .gas_ok_i(gas_ok), .pilot_i(pilot), .spark_i(spark),
    .flame_low_o(flame_low), .flame_high_o(flame_high));
  task automatic final_report;
    $display("Checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  // Bounded wait for one output bit, leaves cycle count in n
  task automatic wait_bit(input int b, input logic v, input int lim);
    n = 0;
    while (outs[b] !== v && n < lim) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    `CHK("wait limit", v, outs[b])
  endtask : wait_bit
  task automatic t_light;
    @(posedge mclk_i);
    sw <= 2'h3;
    gas_ok <= 1'b1;
    heat <= 1'b1;
    wait_bit(2, 1'b1, 30);
    `CHK("spark", 1'b1, spark)
    wait_bit(3, 1'b0, 60);
    `CHK("main early", 2'h2, {pilot, main_v})
    wait_bit(1, 1'b1, 30);
    wait_bit(0, 1'b1, ST * TK + 10);
    `CHK("stab span", 4'hF, {n >= (ST - 1) * TK + 1 && n <= ST * TK, outs[2:0]})
    @(posedge mclk_i);
    gas_ok <= 1'b0;
    wait_bit(2, 1'b0, 20);
    `CHK("flame loss", 2'h0, {pilot, main_v})
    @(posedge mclk_i);
    heat <= 1'b0;
    repeat (12) @(posedge mclk_i);
  endtask : t_light
  // Flame starved after spark-off: spark returns, trial still ends on time, then retries
  task automatic t_fail;
    int tot;
    heat <= 1'b1;
    gas_ok <= 1'b1;
    wait_bit(2, 1'b1, 30);
    wait_bit(3, 1'b0, 60);
    tot = n + 1;
    @(posedge mclk_i);
    gas_ok <= 1'b0;
    wait_bit(3, 1'b1, 30);
    `CHK("spark again", 2'h3, {spark, pilot})
    tot += n;
    wait_bit(2, 1'b0, TR * TK + 10);
    tot += n;
    `CHK("trial span", 3'h4, {tot >= (TR - 1) * TK + 1 && tot <= TR * TK, spark, main_v})
    wait_bit(2, 1'b1, RT * TK + 10);
    `CHK("retry span", 2'h3, {n >= (RT - 1) * TK - 1 && n <= RT * TK + 1, spark})
    wait_bit(2, 1'b0, TR * TK + 10);
    repeat (20) @(posedge mclk_i);
    heat <= 1'b0;
    repeat (20) @(posedge mclk_i);
    heat <= 1'b1;
    wait_bit(2, 1'b1, 30);
    `CHK("fresh trial", 1'b1, pilot)
    @(posedge mclk_i);
    heat <= 1'b0;
    wait_bit(2, 1'b0, 20);
    `CHK("heat off", 3'h0, {spark, pilot, main_v})
  endtask : t_fail
  // Reset during a trial, then the restart and eight more starts leave settings open and the tenth freezes them
  task automatic t_tenth;
    int i;
    @(posedge mclk_i);
    heat <= 1'b1;
    wait_bit(2, 1'b1, 30);
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    `CHK("reset idle", 7'h00, {outs, locked, cfg})
    wait_bit(2, 1'b1, 30);
    `CHK("power back", 2'h3, {spark, pilot})
    for (i = 2; i <= 10; i++) begin
      @(posedge mclk_i);
      heat <= 1'b0;
      sw <= 2'(i);
      wait_bit(2, 1'b0, 30);
      repeat (8) @(posedge mclk_i);
      heat <= 1'b1;
      wait_bit(2, 1'b1, 30);
      `CHK("lock count", {i == 10, 2'(i)}, {locked, cfg})
    end
    @(posedge mclk_i);
    heat <= 1'b0;
    sw <= 2'h1;
    repeat (12) @(posedge mclk_i);
    #1;
    `CHK("tenth lock", 3'h6, {locked, cfg})
  endtask : t_tenth
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    `CHK("idle", 7'h00, {outs, locked, cfg})
    t_light;
    @(posedge mclk_i);
    jumper <= 1'b0;
    repeat (8) @(posedge mclk_i);
    jumper <= 1'b1;
    sw <= 2'h1;
    t_fail;
    `CHK("frozen cfg", 3'h7, {locked, cfg})
    t_tenth;
    final_report;
  end
  // Whole run needs about 5200 cycles
  initial begin
    repeat (20000) @(posedge mclk_i);
    failures++;
    final_report;
  end
endmodule : tb_ipis_sequencer
bind ipis_sequencer ipis_seq_assertions #(.TICK_CYC(TICK_CYC), .TRIAL_S(TRIAL_S)) i_ipis_seq_assertions (
  .mclk_i(mclk_i), .rst_i(rst_i), .heat_request_input_i(heat_request_input_i), .flame_low_i(flame_low_i),
  .flame_high_i(flame_high_i), .spark_o(spark_o), .pilot_valve_output_o(pilot_valve_output_o),
  .main_valve_output_o(main_valve_output_o), .run_o(run_o), .cfg_locked_o(cfg_locked_o), .cfg_o(cfg_o));
